/* File: verification/asr_chk.sv */
// Concurrent checks on the converter, pin-setup and engine ports.
// Assumes it is bound into asr_top by the testbench top file.
`default_nettype none
module asr_chk (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Converter and pin setup
  input wire asr_pkg::asr_adc_rsp_t adc_rsp,
  input wire asr_pkg::asr_adc_req_t adc_req,
  input wire asr_pkg::asr_pin_cfg_t pin_cfg,
  // Motion engine side
  input wire logic                  sensor_scan_hold,
  input wire logic [2:0]            range_code,
  input wire logic [2:0]            range_reach
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // One clock domain, so clocking and reset are stated once.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Service sequence, plus the range mirror on the engine side.
  adc_mode_a: assert property (
    adc_req.start |-> adc_req.single_ended && !adc_req.buffered && adc_req.vref_2v)
    else $error("converter set up in the wrong mode");
  setup_first_a: assert property (
    pin_cfg.we |=> adc_req.start && adc_req.chan == $past(pin_cfg.chan))
    else $error("sampling did not follow pin setup on the same channel");
  setup_once_a: assert property (pin_cfg.we |=> !pin_cfg.we)
    else $error("pin setup strobe longer than one cycle");
  start_stands_a: assert property (
    adc_req.start && !adc_rsp.done |=> adc_req.start)
    else $error("start dropped before the converter answered");
  done_release_a: assert property (
    adc_req.start && adc_rsp.done |=> (sensor_scan_hold && !adc_req.start) ##1 !sensor_scan_hold)
    else $error("service did not end one cycle after the answer");
  scan_paused_a: assert property (
    adc_req.start || pin_cfg.we |-> sensor_scan_hold)
    else $error("sensor scanning not paused during service");
  hold_begin_a: assert property ($rose(sensor_scan_hold) |-> pin_cfg.we)
    else $error("scan hold rose without a pin setup");
  chan_avail_a: assert property (pin_cfg.we |-> pin_cfg.chan != 3'h2)
    else $error("service on a channel without requests");
  range_mirror_a: assert property (range_reach == ~range_code)
    else $error("reach does not shrink as the range code grows");
  // Main scenarios seen at least once.
  cover property (adc_req.start && adc_rsp.done);
  cover property (adc_req.start [*4]);
  cover property (!adc_req.start && adc_rsp.done);
endmodule
`default_nettype wire

/* File: verification/tb_adc_scan_request_service.sv */
// Self-checking bench for the conversion request service top.
// Assumes the 28-pin layout, single pyro, and a converter stand-in here.
`include "asr_params.svh"
`default_nettype none
module tb_adc_scan_request_service;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  TB_VER = 8'hC3; // Arbitrary version code.
  localparam logic [11:0] A_LIT = 12'(`ASR_IDX_LIGHT << 2);
  localparam logic [11:0] A_REQ = 12'(`ASR_IDX_REQ << 2);
  localparam logic [11:0] A_RES = 12'(`ASR_IDX_RESULT << 2);
  localparam logic [11:0] A_VER = 12'(`ASR_IDX_VERSION << 2);
  localparam logic [11:0] A_STS = 12'(`ASR_IDX_IRQ_STS << 2);
  localparam logic [11:0] A_MSK = 12'(`ASR_IDX_IRQ_MSK << 2);
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, dual_pyro_mode = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'hCD6D71F1, d, exp_sts, exp_res;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, irq, hold, light_en, adc_go, spur;
  logic [2:0] range_code, range_reach, pin_seen, adc_chan;
  logic [15:0] adc_val;
  int adc_dly, cnt, n_errors, tests_run;
  asr_pkg::asr_adc_rsp_t adc_rsp = '0;
  asr_pkg::asr_adc_req_t adc_req;
  asr_pkg::asr_pin_cfg_t pin_cfg;
  asr_top #(.PKG_SEL(0), .VERSION_CODE(TB_VER)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .adc_rsp(adc_rsp), .adc_req(adc_req),
    .pin_cfg(pin_cfg), .dual_pyro_mode(dual_pyro_mode), .sensor_scan_hold(hold),
    .range_code(range_code), .range_reach(range_reach), .light_detect_en(light_en),
    .irq(irq));
  // ==========================================================
  // Clock, converter stand-in and monitors.
  always #50 aclk = ~aclk;
  // The stand-in answers a held start after adc_dly cycles; idle data keeps changing.
  always @(posedge aclk) begin
    if (adc_req.start === 1'b1 && adc_go && !adc_rsp.done && cnt >= adc_dly) begin
      adc_rsp <= {1'b1, adc_val};
      adc_chan <= adc_req.chan;
      cnt <= 0;
    end else if (spur) begin
      adc_rsp <= {1'b1, ~adc_val};
    end else begin
      adc_rsp <= {1'b0, ~adc_rsp.data};
      cnt <= (adc_req.start === 1'b1) ? cnt + 1 : 0;
    end
    if (pin_cfg.we === 1'b1) pin_seen <= pin_cfg.chan;
  end
  // ==========================================================
  // Helpers.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write: address and data offered together, each released once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin aw = 1; awvalid <= 1'b0; end
      if (!w && wready === 1'b1) begin w = 1; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // One request, optionally with the converter stalled to test write-zero.
  task automatic serve(input logic [7:0] v, input int ch, input bit slow);
    int n;
    adc_val = xs();
    adc_dly = xs() % 5;
    adc_go <= !slow;
    wr(A_REQ, {24'h0, v}, r);
    if (slow) begin
      wr(A_REQ, 32'h0, r);
      rd(A_REQ, d, r);
      check_val(d, {24'h0, v & 8'hF3});
      adc_go <= 1'b1;
    end
    n = 0;
    do begin rd(A_REQ, d, r); n++; end while (d !== 32'h0 && n < 100);
    check_val(d, 32'h0);
    exp_res = {16'h0, adc_val};
    exp_sts = exp_sts | (((v & (v - 8'h01)) != 8'h00) ? 32'h3 : 32'h1);
    check_val({29'h0, pin_seen}, 32'(ch));
    check_val({29'h0, adc_chan}, 32'(ch));
    rd(A_RES, d, r);
    check_val(d, exp_res);
    rd(A_STS, d, r);
    check_val(d, exp_sts);
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Main sequence; the watchdog shares the closing task.
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    static int chs[6] = '{0, 1, 4, 5, 6, 7};
    adc_go = 1'b1; spur = 1'b0; cnt = 0; adc_dly = 0; exp_sts = 0; exp_res = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_REQ, d, r);
    check_val(d, 32'h0);
    rd(A_RES, d, r);
    check_val(d, 32'h0);
    wr(A_VER, 32'hFF, r);
    rd(A_VER, d, r);
    check_val(d, {24'h0, TB_VER});
    wr(12'h7F0, 32'h1, r);
    check_val({30'h0, r}, {30'h0, `ASR_RESP_SLVERR});
    rd(12'h7F0, d, r);
    check_val({30'h0, r}, {30'h0, `ASR_RESP_SLVERR});
    for (int i = 0; i < 8; i++) begin
      wr(A_LIT, {24'h0, 5'h00, 3'(i)}, r);
      check_val({29'h0, range_reach}, {29'h0, ~3'(i)});
      check_val({29'h0, range_code}, 32'(i));
    end
    wr(A_LIT, {24'h0, 5'h01, 3'h5}, r);
    check_val({31'h0, light_en}, 32'h1);
    wr(A_REQ, 32'h02, r);
    rd(A_REQ, d, r);
    check_val(d, 32'h0);
    wr(A_LIT, 32'h0, r);
    check_val({31'h0, light_en}, 32'h0);
    wr(A_REQ, 32'h0C, r);
    rd(A_REQ, d, r);
    check_val(d, 32'h04);
    check_val({31'h0, hold}, 32'h0);
    wr(A_REQ, 32'h0, r);
    foreach (chs[k]) serve(8'(1 << chs[k]), chs[k], 1'b0);
    serve(8'h10, 4, 1'b1);
    serve(8'hF2, 1, 1'b0);
    @(posedge aclk);
    spur <= 1'b1;
    @(posedge aclk);
    spur <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(A_RES, d, r);
    check_val(d, exp_res);
    check_val({31'h0, irq}, 32'h0);
    wr(A_MSK, 32'h1, r);
    check_val({31'h0, irq}, 32'h1);
    wr(A_STS, 32'h3, r);
    exp_sts = 0;
    check_val({31'h0, irq}, 32'h0);
    wr(A_MSK, 32'h2, r);
    serve(8'h01, 0, 1'b0);
    check_val({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule
bind asr_top asr_chk i_chk (.aclk(aclk), .aresetn(aresetn), .adc_rsp(adc_rsp),
  .adc_req(adc_req), .pin_cfg(pin_cfg), .sensor_scan_hold(sensor_scan_hold),
  .range_code(range_code), .range_reach(range_reach));
`default_nettype wire

/* File: verilog/asr_conv_seq.sv */
// Service sequencer: picks a channel, sets the pin up, samples.
// Assumes the converter answers each start with one done pulse.
`include "asr_params.svh"
`default_nettype none
module asr_conv_seq (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Pending request bits
  input  wire logic [7:0]           pending,
  // Converter and pin
  input  wire asr_pkg::asr_adc_rsp_t adc_rsp,
  output asr_pkg::asr_adc_req_t     adc_req,
  output asr_pkg::asr_pin_cfg_t     pin_cfg,
  // Results and events
  output logic                      hold,
  output logic                      clear_all,
  output logic                      drop_evt,
  output logic [15:0]               sample
);
  asr_pkg::asr_state_t state_ff;
  asr_pkg::asr_state_t nxt_state;
  logic [2:0]  chan_ff;
  logic [2:0]  nxt_chan;
  logic        drop_ff;
  logic        nxt_drop;
  logic [15:0] sample_ff;
  logic [15:0] nxt_sample;
  logic [7:0]  lowest;
  // ========================================================
  // One-hot lowest request, so only one channel is served.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_low
      if (gi == 0) begin : g_first
        assign lowest[gi] = pending[gi];
      end else begin : g_rest
        assign lowest[gi] = pending[gi] & ~|pending[gi-1:0];
      end
    end
  endgenerate
  // Next state of the sequencer.
  always_comb begin
    nxt_state  = state_ff;
    nxt_chan   = chan_ff;
    nxt_drop   = drop_ff;
    nxt_sample = sample_ff;
    case (state_ff)
      asr_pkg::ST_IDLE: begin
        if (|pending) begin
          nxt_state = asr_pkg::ST_CONFIG;
          nxt_drop  = (pending != lowest);
          for (int i = 0; i < 8; i++) begin
            if (lowest[i]) begin
              nxt_chan = 3'(i);
            end
          end
        end
      end
      asr_pkg::ST_CONFIG: nxt_state = asr_pkg::ST_SAMPLE;
      asr_pkg::ST_SAMPLE: begin
        if (adc_rsp.done) begin
          nxt_sample = adc_rsp.data;
          nxt_state  = asr_pkg::ST_DONE;
        end
      end
      asr_pkg::ST_DONE: nxt_state = asr_pkg::ST_IDLE;
      default: nxt_state = asr_pkg::ST_IDLE;
    endcase
  end
  // State registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff  <= asr_pkg::ST_IDLE;
      chan_ff   <= 3'h0;
      drop_ff   <= 1'b0;
      sample_ff <= `ASR_RST_RESULT;
    end else begin
      state_ff  <= nxt_state;
      chan_ff   <= nxt_chan;
      drop_ff   <= nxt_drop;
      sample_ff <= nxt_sample;
    end
  end
  // Outputs; the pin is left in analog mode afterwards.
  assign pin_cfg.we          = (state_ff == asr_pkg::ST_CONFIG);
  assign pin_cfg.chan        = chan_ff;
  assign adc_req.start       = (state_ff == asr_pkg::ST_SAMPLE);
  assign adc_req.chan        = chan_ff;
  assign adc_req.single_ended = 1'b1;
  assign adc_req.buffered    = 1'b0;
  assign adc_req.vref_2v     = 1'b1;
  assign hold      = (state_ff != asr_pkg::ST_IDLE);
  assign clear_all = (state_ff == asr_pkg::ST_DONE);
  assign drop_evt  = clear_all & drop_ff;
  assign sample    = sample_ff;
endmodule
`default_nettype wire

/* File: verilog/asr_params.svh */
// Constants for the auxiliary conversion request service.
// Assumes a 10 MHz aclk and a 32-bit AXI4-Lite register bus.
// What this block does
// - Larger range value gives shorter detection range.
// - Software sets request bits; only hardware clears.
// - Serviced pin becomes single-ended unbuffered, 2 V.
// - Store next sample, then clear all requests.
// - Several requests: lowest channel wins, rest dropped.
// - Sensor conversions pause during service.
// - One means requested, zero means idle/done.
// - Requests only on channels 0, 1, 3-7.
// - Result holds latest requested conversion.
// - Result changes only when a request completes.
// - Read-only register gives engine version code.
// - Zero light threshold frees channel one.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH
// ==========================================================
// Register indices and byte addresses (byte = 4 * index)
`define ASR_ADDR_W        12
`define ASR_IDX_LIGHT     12'h104
`define ASR_IDX_REQ       12'h105
`define ASR_IDX_RESULT    12'h10A
`define ASR_IDX_VERSION   12'h10C
`define ASR_IDX_IRQ_STS   12'h110
`define ASR_IDX_IRQ_MSK   12'h111
// ==========================================================
// Field positions and masks
`define ASR_REQ_CHANNELS  8'hFB
`define ASR_BUF_MODE_BIT  2
`define ASR_LIGHT_BIT     1
`define ASR_WM_28PIN      8'hF7
`define ASR_WM_20PIN      8'h73
`define ASR_WM_8PIN       8'h0B
`define ASR_PYRO2_BIT20   6
`define ASR_PYRO2_BIT8    3
`define ASR_IRQ_DONE      0
`define ASR_IRQ_DROP      1
// ==========================================================
// Reset values and bus answers
`define ASR_RST_REQ       8'h00
`define ASR_RST_LIGHT     8'h00
`define ASR_RST_RESULT    16'h0000
`define ASR_RST_IRQ       2'h0
`define ASR_RESP_OKAY     2'h0
`define ASR_RESP_SLVERR   2'h2
`endif

/* File: verilog/asr_pkg.sv */
// Types shared by the conversion request service modules.
// Assumes asr_params.svh is available for the constants.
`default_nettype none
package asr_pkg;
  // ========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_CONFIG = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_DONE   = 2'b11
  } asr_state_t;
  // ========================================================
  // Converter request toward the analog front end
  typedef struct packed {
    logic       start;
    logic [2:0] chan;
    logic       single_ended;
    logic       buffered;
    logic       vref_2v;
  } asr_adc_req_t;
  // Converter answer
  typedef struct packed {
    logic        done;
    logic [15:0] data;
  } asr_adc_rsp_t;
  // Pin reconfiguration strobe
  typedef struct packed {
    logic       we;
    logic [2:0] chan;
  } asr_pin_cfg_t;
endpackage
`default_nettype wire

/* File: verilog/asr_top.sv */
// Top of the auxiliary conversion request service with its
// AXI4-Lite register slave and interrupt logic.
// Assumes one converter and pin-setup port outside the block.
//
// Local design decision: register access over AXI4-Lite.
`include "asr_params.svh"
`default_nettype none
module asr_top #(
  parameter int          PKG_SEL      = 0,
  parameter logic [7:0]  VERSION_CODE = 8'h5A // Arbitrary value.
) (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address and data
  input  wire logic [`ASR_ADDR_W-1:0]  awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // AXI4-Lite write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // AXI4-Lite read
  input  wire logic [`ASR_ADDR_W-1:0]  araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // Converter and pin setup
  input  wire asr_pkg::asr_adc_rsp_t   adc_rsp,
  output asr_pkg::asr_adc_req_t        adc_req,
  output asr_pkg::asr_pin_cfg_t        pin_cfg,
  // Motion engine side
  input  wire logic                    dual_pyro_mode,
  output logic                         sensor_scan_hold,
  output logic [2:0]                   range_code,
  output logic [2:0]                   range_reach,
  output logic                         light_detect_en,
  // Interrupt
  output logic                         irq
);
  // ========================================================
  // Byte addresses of the registers.
  localparam logic [`ASR_ADDR_W-1:0] A_LIGHT = `ASR_ADDR_W'(`ASR_IDX_LIGHT * 4);
  localparam logic [`ASR_ADDR_W-1:0] A_REQ   = `ASR_ADDR_W'(`ASR_IDX_REQ * 4);
  localparam logic [`ASR_ADDR_W-1:0] A_RES   = `ASR_ADDR_W'(`ASR_IDX_RESULT * 4);
  localparam logic [`ASR_ADDR_W-1:0] A_VER   = `ASR_ADDR_W'(`ASR_IDX_VERSION * 4);
  localparam logic [`ASR_ADDR_W-1:0] A_STS   = `ASR_ADDR_W'(`ASR_IDX_IRQ_STS * 4);
  localparam logic [`ASR_ADDR_W-1:0] A_MSK   = `ASR_ADDR_W'(`ASR_IDX_IRQ_MSK * 4);

  // ========================================================
  // Storage
  logic                    aw_have_ff;
  logic                    nxt_aw_have;
  logic [`ASR_ADDR_W-1:0]  aw_addr_ff;
  logic [`ASR_ADDR_W-1:0]  nxt_aw_addr;
  logic                    w_have_ff;
  logic                    nxt_w_have;
  logic [7:0]              w_data_ff;
  logic [7:0]              nxt_w_data;
  logic                    w_lane_ff;
  logic                    nxt_w_lane;
  logic                    bvalid_ff;
  logic                    nxt_bvalid;
  logic [1:0]              bresp_ff;
  logic [1:0]              nxt_bresp;
  logic                    rvalid_ff;
  logic                    nxt_rvalid;
  logic [31:0]             rdata_ff;
  logic [31:0]             nxt_rdata;
  logic [1:0]              rresp_ff;
  logic [1:0]              nxt_rresp;
  logic [7:0]              req_ff;
  logic [7:0]              nxt_req;
  logic [7:0]              light_ff;
  logic [7:0]              nxt_light;
  logic [15:0]             result_ff;
  logic [15:0]             nxt_result;
  logic [1:0]              sts_ff;
  logic [1:0]              nxt_sts;
  logic [1:0]              msk_ff;
  logic [1:0]              nxt_msk;

  // Write-phase signals
  logic                    aw_take;
  logic                    w_take;
  logic                    wr_go;
  logic [`ASR_ADDR_W-1:0]  wr_addr;
  logic [7:0]              wr_byte;
  logic                    wr_lane0;
  logic                    wr_mapped;

  // Register-view signals
  logic [7:0]              wmask;
  logic [7:0]              req_view;
  logic [7:0]              pending;
  logic                    seq_clear;
  logic                    seq_drop;
  logic [15:0]             seq_sample;
  logic                    done_evt;

  // ========================================================
  // Writable request bits by package and mode; bit one is
  // taken by the light sensor while its threshold is set.
  always_comb begin
    case (PKG_SEL)
      1: begin
        wmask = `ASR_WM_20PIN;
        if (!dual_pyro_mode) begin
          wmask[`ASR_PYRO2_BIT20] = 1'b0;
        end
      end
      2: begin
        wmask = `ASR_WM_8PIN;
        if (dual_pyro_mode) begin
          wmask[`ASR_PYRO2_BIT8] = 1'b0;
        end
      end
      default: wmask = `ASR_WM_28PIN;
    endcase
    if (light_ff[7:3] != 5'h00) begin
      wmask[`ASR_LIGHT_BIT] = 1'b0;
    end
  end

  // Reserved positions read zero; channel two never requests.
  assign req_view = req_ff & wmask;
  assign pending  = req_view & `ASR_REQ_CHANNELS;

  // ========================================================
  // Write channel: address and data may come in either order.
  assign awready = !aw_have_ff && !bvalid_ff;
  assign wready  = !w_have_ff && !bvalid_ff;
  assign aw_take = awvalid && awready;
  assign w_take  = wvalid && wready;
  assign wr_go   = (aw_have_ff || aw_take) && (w_have_ff || w_take);
  assign wr_addr = aw_have_ff ? aw_addr_ff : awaddr;
  assign wr_byte = w_have_ff ? w_data_ff : wdata[7:0];
  assign wr_lane0 = w_have_ff ? w_lane_ff : wstrb[0];

  // Mapped words answer OKAY; writes to read-only words are dropped.
  always_comb begin
    case (wr_addr)
      A_LIGHT, A_REQ, A_STS, A_MSK: wr_mapped = 1'b1;
      A_RES, A_VER:                 wr_mapped = 1'b1;
      default:                      wr_mapped = 1'b0;
    endcase
  end

  // Next values of the write handshake.
  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_have  = w_have_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_lane  = w_lane_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (aw_take) begin
      nxt_aw_have = 1'b1;
      nxt_aw_addr = awaddr;
    end
    if (w_take) begin
      nxt_w_have = 1'b1;
      nxt_w_data = wdata[7:0];
      nxt_w_lane = wstrb[0];
    end
    if (wr_go) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_mapped ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
    end else if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_have_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_lane_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `ASR_RESP_OKAY;
    end else begin
      aw_have_ff <= nxt_aw_have;
      aw_addr_ff <= nxt_aw_addr;
      w_have_ff  <= nxt_w_have;
      w_data_ff  <= nxt_w_data;
      w_lane_ff  <= nxt_w_lane;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;

  // ========================================================
  // Register file. Software can only add request bits, and a
  // set in the clearing cycle survives the clear.
  always_comb begin
    nxt_req    = req_ff;
    nxt_light  = light_ff;
    nxt_msk    = msk_ff;
    nxt_result = result_ff;
    if (seq_clear) begin
      nxt_req    = req_ff & ~`ASR_REQ_CHANNELS;
      nxt_result = seq_sample;
    end
    if (wr_go && wr_lane0) begin
      case (wr_addr)
        A_REQ: begin
          nxt_req = nxt_req | (wr_byte & wmask & `ASR_REQ_CHANNELS);
          nxt_req[`ASR_BUF_MODE_BIT] = wr_byte[`ASR_BUF_MODE_BIT]
                                     & wmask[`ASR_BUF_MODE_BIT];
        end
        A_LIGHT: nxt_light = wr_byte;
        A_MSK:   nxt_msk   = wr_byte[1:0];
        default: nxt_light = nxt_light;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_ff    <= `ASR_RST_REQ;
      light_ff  <= `ASR_RST_LIGHT;
      msk_ff    <= `ASR_RST_IRQ;
      result_ff <= `ASR_RST_RESULT;
    end else begin
      req_ff    <= nxt_req;
      light_ff  <= nxt_light;
      msk_ff    <= nxt_msk;
      result_ff <= nxt_result;
    end
  end

  // ========================================================
  // Interrupt status: write one to clear, an event wins.
  assign done_evt = seq_clear;
  always_comb begin
    nxt_sts = sts_ff;
    if (wr_go && wr_lane0 && (wr_addr == A_STS)) begin
      nxt_sts = sts_ff & ~wr_byte[1:0];
    end
    if (done_evt) begin
      nxt_sts[`ASR_IRQ_DONE] = 1'b1;
    end
    if (seq_drop) begin
      nxt_sts[`ASR_IRQ_DROP] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_ff    <= `ASR_RST_IRQ;
    end else begin
      sts_ff    <= nxt_sts;
    end
  end

  assign irq = |(sts_ff & msk_ff);

  // ========================================================
  // Read channel: one word at a time, answered next cycle.
  assign arready = !rvalid_ff;
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = `ASR_RESP_OKAY;
      case (araddr)
        A_LIGHT: nxt_rdata = {24'h000000, light_ff};
        A_REQ:   nxt_rdata = {24'h000000, req_view};
        A_RES:   nxt_rdata = {16'h0000, result_ff};
        A_VER:   nxt_rdata = {24'h000000, VERSION_CODE};
        A_STS:   nxt_rdata = {30'h00000000, sts_ff};
        A_MSK:   nxt_rdata = {30'h00000000, msk_ff};
        default: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = `ASR_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `ASR_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata  = rdata_ff;
  assign rresp  = rresp_ff;

  // ========================================================
  // Motion engine controls. The reach output falls as the
  // programmed range grows; it is the bit-wise complement.
  assign range_code      = light_ff[2:0];
  assign range_reach     = ~light_ff[2:0];
  assign light_detect_en = (light_ff[7:3] != 5'h00);

  // ========================================================
  // Service sequencer.
  asr_conv_seq u_seq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pending   (pending),
    .adc_rsp   (adc_rsp),
    .adc_req   (adc_req),
    .pin_cfg   (pin_cfg),
    .hold      (sensor_scan_hold),
    .clear_all (seq_clear),
    .drop_evt  (seq_drop),
    .sample    (seq_sample)
  );

endmodule
`default_nettype wire
